/* File: parity_report_pkg.sv */
`default_nettype none
package parity_report_pkg;

  localparam int DATA_W = 32;
  localparam int CBE_W = 4;
  localparam int ADDR_W = 4;
  localparam int REG_W = 32;

  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] MASK_OFS = 4'h8;

  // control register fields
  localparam int CTRL_PRI_RESP_BIT = 0;
  localparam int CTRL_SEC_RESP_BIT = 1;
  localparam int CTRL_SERR_EN_BIT = 2;
  localparam int CTRL_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;

  // status / mask register fields
  localparam int ST_SEC_MDPD = 0;
  localparam int ST_SEC_DPE = 1;
  localparam int ST_PRI_DPE = 2;
  localparam int ST_PRI_PERR = 3;
  localparam int ST_SEC_PERR = 4;
  localparam int ST_SERR = 5;
  localparam int N_STATUS = 6;
  localparam logic [N_STATUS-1:0] STATUS_RST = 6'h00;
  localparam logic [N_STATUS-1:0] MASK_RST = 6'h00;

  // bus indices
  localparam int BUS_PRI = 0;
  localparam int BUS_SEC = 1;

  // timing in clocks
  localparam int PERR_DELAY_CYC = 2;
  localparam int SYNC_STAGES = 2;
  localparam int OWN_TAP = PERR_DELAY_CYC - 1;
  localparam int REMOTE_TAP = PERR_DELAY_CYC + SYNC_STAGES - 1;
  localparam int PIPE_DEPTH = REMOTE_TAP + 1;

  typedef enum logic [1:0] {KIND_READ, KIND_POSTED, KIND_DELAYED} xact_kind_e;
  typedef enum logic {DIR_DOWN, DIR_UP} dir_e;

  typedef struct packed {
    logic valid;
    xact_kind_e kind;
    dir_e dir;
    logic poisoned;
  } ctx_s;

  // bridge takes the data on this bus: target of a write or initiator of a read
  function automatic logic is_receiver(input logic sec_bus, input xact_kind_e kind, input dir_e dir);
    logic up_bus;
    up_bus = sec_bus ? (dir == DIR_DOWN) : (dir == DIR_UP);
    return (kind == KIND_READ) == up_bus;
  endfunction : is_receiver

  // bridge is master on this bus
  function automatic logic is_master(input logic sec_bus, input dir_e dir);
    return sec_bus ? (dir == DIR_DOWN) : (dir == DIR_UP);
  endfunction : is_master

endpackage : parity_report_pkg
`default_nettype wire

/* File: parity_port_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface parity_port_if #(parameter int DATA_W = 32, parameter int CBE_W = 4);
  logic dphase;
  logic [DATA_W-1:0] ad;
  logic [CBE_W-1:0] cbe;
  logic par;
  logic check_en;
  logic relay_take;
  logic resp_en;
  logic err_found;
  logic perr_n;
  logic perr_oe_n;

  modport port (
    input dphase, ad, cbe, par, check_en, relay_take, resp_en,
    output err_found, perr_n, perr_oe_n
  );
  modport core (
    output dphase, ad, cbe, par, check_en, relay_take, resp_en,
    input err_found, perr_n, perr_oe_n
  );
endinterface : parity_port_if
`default_nettype wire

/* File: bus_parity_port.sv */
`timescale 1ns/10ps
`default_nettype none
module bus_parity_port (
  input wire logic clock,
  input wire logic rst_n,
  parity_port_if.port bus
);
  logic calc_q;
  logic chk_q;
  logic take_q;
  logic hold_q;
  logic err;
  logic fire;

  // par trails its data phase by one clock, so the check lands one clock later
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      calc_q <= 1'b0;
      chk_q <= 1'b0;
      take_q <= 1'b0;
    end else begin
      calc_q <= ^{bus.ad, bus.cbe};
      chk_q <= bus.dphase & bus.check_en;
      take_q <= bus.dphase & bus.relay_take;
    end
  end

  assign err = chk_q & (calc_q ^ bus.par);
  // a relay still obeys this bus's response bit, even if it was cleared while pending
  assign fire = (err | take_q) & bus.resp_en;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus.err_found <= 1'b0;
    end else begin
      bus.err_found <= err;
    end
  end

  // low for one clock, driven high one more clock, then released
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus.perr_n <= 1'b1;
      bus.perr_oe_n <= 1'b1;
      hold_q <= 1'b0;
    end else if (fire) begin
      bus.perr_n <= 1'b0;
      bus.perr_oe_n <= 1'b0;
      hold_q <= 1'b1;
    end else if (hold_q) begin
      bus.perr_n <= 1'b1;
      bus.perr_oe_n <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      bus.perr_n <= 1'b1;
      bus.perr_oe_n <= 1'b1;
    end
  end
endmodule : bus_parity_port
`default_nettype wire

/* File: sticky_status.sv */
`timescale 1ns/10ps
`default_nettype none
module sticky_status #(
  parameter int N = 6,
  parameter logic [N-1:0] STATUS_INIT = '0,
  parameter logic [N-1:0] MASK_INIT = '0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [N-1:0] set,
  input wire logic wr_status,
  input wire logic wr_mask,
  input wire logic [N-1:0] wdata,
  output logic [N-1:0] status_q,
  output logic [N-1:0] mask_q,
  output logic irq_q
);
  logic [N-1:0] status_d;

  // set beats a write-one clear in the same cycle
  for (genvar i = 0; i < N; i++) begin : g_bit
    assign status_d[i] = set[i] | (status_q[i] & ~(wr_status & wdata[i]));
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= STATUS_INIT;
    end else begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= MASK_INIT;
    end else if (wr_mask) begin
      mask_q <= wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_d & (wr_mask ? wdata : mask_q));
    end
  end
endmodule : sticky_status
`default_nettype wire

/* File: bridge_parity_error_report.sv */
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module bridge_parity_error_report (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [parity_report_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [parity_report_pkg::REG_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [parity_report_pkg::REG_W-1:0] reg_rdata,
  input wire logic pri_dphase,
  input wire logic [parity_report_pkg::DATA_W-1:0] pri_ad,
  input wire logic [parity_report_pkg::CBE_W-1:0] pri_cbe,
  input wire logic pri_par,
  input wire parity_report_pkg::xact_kind_e pri_kind,
  input wire parity_report_pkg::dir_e pri_dir,
  input wire logic pri_poisoned,
  input wire logic sec_dphase,
  input wire logic [parity_report_pkg::DATA_W-1:0] sec_ad,
  input wire logic [parity_report_pkg::CBE_W-1:0] sec_cbe,
  input wire logic sec_par,
  input wire parity_report_pkg::xact_kind_e sec_kind,
  input wire parity_report_pkg::dir_e sec_dir,
  input wire logic sec_poisoned,
  input wire logic primary_parity_err_n_i,
  output logic primary_parity_err_n_o,
  output logic primary_parity_err_n_oe_n,
  input wire logic secondary_parity_err_n_i,
  output logic secondary_parity_err_n_o,
  output logic secondary_parity_err_n_oe_n,
  output logic primary_system_err_n_o,
  output logic primary_system_err_n_oe_n,
  output logic pri_err_detected,
  output logic sec_err_detected,
  output logic irq
);
  import parity_report_pkg::*;

  parity_port_if #(.DATA_W(DATA_W), .CBE_W(CBE_W)) pri_if ();
  parity_port_if #(.DATA_W(DATA_W), .CBE_W(CBE_W)) sec_if ();

  logic [CTRL_W-1:0] ctrl_q;
  logic pri_resp;
  logic sec_resp;
  logic serr_en;
  logic both_resp;

  logic [N_STATUS-1:0] status_set;
  logic [N_STATUS-1:0] status_q;
  logic [N_STATUS-1:0] mask_q;

  ctx_s ctx_in [2];
  ctx_s ctx_q [2][PIPE_DEPTH];
  logic perr_pin_n [2];
  logic perr_meta_q [2];
  logic perr_seen_q [2];
  logic own_err [2];
  logic remote_perr [2];
  logic relay_set [2];
  logic relay_take [2];
  logic relay_pend_q [2];
  logic serr_evt [2];
  logic serr_fire;
  logic [REG_W-1:0] rdata_d;

  assign pri_resp = ctrl_q[CTRL_PRI_RESP_BIT];
  assign sec_resp = ctrl_q[CTRL_SEC_RESP_BIT];
  assign serr_en = ctrl_q[CTRL_SERR_EN_BIT];
  assign both_resp = pri_resp & sec_resp;

  // ---- register bus ----
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
    end else if (reg_wr && reg_addr == CTRL_OFS) begin
      ctrl_q <= reg_wdata[CTRL_W-1:0];
    end
  end

  always_comb begin
    rdata_d = '0;
    case (reg_addr)
      CTRL_OFS: rdata_d[CTRL_W-1:0] = ctrl_q;
      STATUS_OFS: rdata_d[N_STATUS-1:0] = status_q;
      MASK_OFS: rdata_d[N_STATUS-1:0] = mask_q;
      default: rdata_d = '0;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rdata_d : '0;
    end
  end

  sticky_status #(
    .N(N_STATUS),
    .STATUS_INIT(STATUS_RST),
    .MASK_INIT(MASK_RST)
  ) u_status (
    .clock(clock),
    .rst_n(rst_n),
    .set(status_set),
    .wr_status(reg_wr && reg_addr == STATUS_OFS),
    .wr_mask(reg_wr && reg_addr == MASK_OFS),
    .wdata(reg_wdata[N_STATUS-1:0]),
    .status_q(status_q),
    .mask_q(mask_q),
    .irq_q(irq)
  );

  // ---- per-bus parity ports ----
  always_comb begin
    ctx_in[BUS_PRI] = '{valid: pri_dphase, kind: pri_kind, dir: pri_dir, poisoned: pri_poisoned};
    ctx_in[BUS_SEC] = '{valid: sec_dphase, kind: sec_kind, dir: sec_dir, poisoned: sec_poisoned};
  end

  assign perr_pin_n[BUS_PRI] = primary_parity_err_n_i;
  assign perr_pin_n[BUS_SEC] = secondary_parity_err_n_i;

  // relayed error goes out on the next data phase of the same delayed write
  // idle kind/dir lines alone must not consume a pending relay
  assign relay_take[BUS_PRI] = relay_pend_q[BUS_PRI] & pri_dphase & (pri_kind == KIND_DELAYED)
    & (pri_dir == DIR_DOWN);
  assign relay_take[BUS_SEC] = relay_pend_q[BUS_SEC] & sec_dphase & (sec_kind == KIND_DELAYED)
    & (sec_dir == DIR_UP);

  assign pri_if.dphase = pri_dphase;
  assign pri_if.ad = pri_ad;
  assign pri_if.cbe = pri_cbe;
  assign pri_if.par = pri_par;
  assign pri_if.check_en = is_receiver(1'b0, pri_kind, pri_dir);
  assign pri_if.relay_take = relay_take[BUS_PRI];
  assign pri_if.resp_en = pri_resp;

  assign sec_if.dphase = sec_dphase;
  assign sec_if.ad = sec_ad;
  assign sec_if.cbe = sec_cbe;
  assign sec_if.par = sec_par;
  assign sec_if.check_en = is_receiver(1'b1, sec_kind, sec_dir);
  assign sec_if.relay_take = relay_take[BUS_SEC];
  assign sec_if.resp_en = sec_resp;

  bus_parity_port u_pri_port (
    .clock(clock),
    .rst_n(rst_n),
    .bus(pri_if.port)
  );

  bus_parity_port u_sec_port (
    .clock(clock),
    .rst_n(rst_n),
    .bus(sec_if.port)
  );

  assign own_err[BUS_PRI] = pri_if.err_found;
  assign own_err[BUS_SEC] = sec_if.err_found;

  assign primary_parity_err_n_o = pri_if.perr_n;
  assign primary_parity_err_n_oe_n = pri_if.perr_oe_n;
  assign secondary_parity_err_n_o = sec_if.perr_n;
  assign secondary_parity_err_n_oe_n = sec_if.perr_oe_n;
  assign pri_err_detected = pri_if.err_found;
  assign sec_err_detected = sec_if.err_found;

  // ---- context pipes, error pin sampling and relays ----
  for (genvar b = 0; b < 2; b++) begin : g_bus
    localparam int OTHER = 1 - b;
    ctx_s rctx;

    assign rctx = ctx_q[b][REMOTE_TAP];

    // context follows its data phase so it lines up with the error report
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        for (int i = 0; i < PIPE_DEPTH; i++) begin
          ctx_q[b][i] <= '0;
        end
      end else begin
        ctx_q[b][0] <= ctx_in[b];
        for (int i = 1; i < PIPE_DEPTH; i++) begin
          ctx_q[b][i] <= ctx_q[b][i-1];
        end
      end
    end

    // error pin is driven by another agent, so resynchronise it
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        perr_meta_q[b] <= 1'b1;
        perr_seen_q[b] <= 1'b0;
      end else begin
        perr_meta_q[b] <= perr_pin_n[b];
        perr_seen_q[b] <= ~perr_meta_q[b];
      end
    end

    // target reported an error on data the bridge wrote as master
    assign remote_perr[b] = perr_seen_q[b] & rctx.valid & is_master(b == BUS_SEC, rctx.dir)
      & (rctx.kind != KIND_READ);

    assign relay_set[b] = remote_perr[OTHER] & (ctx_q[OTHER][REMOTE_TAP].kind == KIND_DELAYED) & both_resp;

    // a new relay request outlives a take in the same cycle
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        relay_pend_q[b] <= 1'b0;
      end else begin
        relay_pend_q[b] <= relay_set[b] | (relay_pend_q[b] & ~relay_take[b]);
      end
    end

    // poisoned data carries an error the bridge already saw as target
    assign serr_evt[b] = remote_perr[b] & (rctx.kind == KIND_POSTED) & ~rctx.poisoned;
  end

  // ---- system error ----
  assign serr_fire = (serr_evt[BUS_PRI] | serr_evt[BUS_SEC]) & both_resp & serr_en;

  // open drain: one clock low, otherwise released
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      primary_system_err_n_o <= 1'b1;
      primary_system_err_n_oe_n <= 1'b1;
    end else begin
      primary_system_err_n_o <= ~serr_fire;
      primary_system_err_n_oe_n <= ~serr_fire;
    end
  end

  // ---- status events ----
  always_comb begin
    status_set = '0;
    status_set[ST_SEC_MDPD] = sec_resp & (remote_perr[BUS_SEC] | (own_err[BUS_SEC] &
      (ctx_q[BUS_SEC][OWN_TAP].kind == KIND_READ) & is_master(1'b1, ctx_q[BUS_SEC][OWN_TAP].dir)));
    status_set[ST_SEC_DPE] = own_err[BUS_SEC];
    status_set[ST_PRI_DPE] = own_err[BUS_PRI];
    status_set[ST_PRI_PERR] = ~pri_if.perr_n & ~pri_if.perr_oe_n;
    status_set[ST_SEC_PERR] = ~sec_if.perr_n & ~sec_if.perr_oe_n;
    status_set[ST_SERR] = serr_fire;
  end
endmodule : bridge_parity_error_report
`default_nettype wire

/* File: bridge_parity_error_report_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module bridge_parity_error_report_sva
  import parity_report_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [parity_report_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [parity_report_pkg::REG_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic pri_dphase,
  input wire parity_report_pkg::xact_kind_e pri_kind,
  input wire parity_report_pkg::dir_e pri_dir,
  input wire logic pri_poisoned,
  input wire logic sec_dphase,
  input wire parity_report_pkg::xact_kind_e sec_kind,
  input wire parity_report_pkg::dir_e sec_dir,
  input wire logic sec_poisoned,
  input wire logic primary_parity_err_n_o,
  input wire logic primary_parity_err_n_oe_n,
  input wire logic secondary_parity_err_n_o,
  input wire logic primary_system_err_n_o,
  input wire logic primary_system_err_n_oe_n,
  input wire logic pri_err_detected,
  input wire logic sec_err_detected
);
  logic [CTRL_W-1:0] ctrl_q;
  // shadow of the control register, only written bits matter
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
    end else if (reg_wr && reg_addr == CTRL_OFS) begin
      ctrl_q <= reg_wdata[CTRL_W-1:0];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_pri_resp_gate: assert property ($fell(primary_parity_err_n_o) |-> ctrl_q[CTRL_PRI_RESP_BIT])
    else $error("primary pin driven with response off");
  a_sec_resp_gate: assert property ($fell(secondary_parity_err_n_o) |-> ctrl_q[CTRL_SEC_RESP_BIT])
    else $error("secondary pin driven with response off");
  a_pri_err_cause: assert property (pri_err_detected |-> $past(pri_dphase, 2) &&
    (($past(pri_kind, 2) == KIND_READ) == ($past(pri_dir, 2) == DIR_UP))) else $error("primary check out of place");
  a_sec_err_cause: assert property (sec_err_detected |-> $past(sec_dphase, 2) &&
    (($past(sec_kind, 2) == KIND_READ) == ($past(sec_dir, 2) == DIR_DOWN))) else $error("secondary check misplaced");
  a_pri_own_drive: assert property (pri_err_detected && ctrl_q[0] |-> !primary_parity_err_n_o &&
    !primary_parity_err_n_oe_n) else $error("primary pin not driven on own error");
  a_pri_drive_hold: assert property ($fell(primary_parity_err_n_o) |=> !primary_parity_err_n_oe_n)
    else $error("primary pin released too early");
  a_serr_enables: assert property (!primary_system_err_n_oe_n |-> ctrl_q == 3'h7)
    else $error("system error without enables");
  a_serr_cause: assert property (!primary_system_err_n_oe_n |-> !primary_system_err_n_o &&
    (($past(sec_dphase, 5) && $past(sec_kind, 5) == KIND_POSTED && $past(sec_dir, 5) == DIR_DOWN
      && !$past(sec_poisoned, 5))
    || ($past(pri_dphase, 5) && $past(pri_kind, 5) == KIND_POSTED && $past(pri_dir, 5) == DIR_UP
      && !$past(pri_poisoned, 5))))
    else $error("system error without posted write cause");
  a_serr_pulse: assert property (!primary_system_err_n_oe_n |=> primary_system_err_n_oe_n)
    else $error("system error longer than one cycle");
  c_pri_err: cover property (pri_err_detected);
  c_sec_err: cover property (sec_err_detected);
  c_serr: cover property (!primary_system_err_n_oe_n);
endmodule : bridge_parity_error_report_sva
bind bridge_parity_error_report bridge_parity_error_report_sva u_bridge_parity_error_report_sva (.*);
`default_nettype wire

/* File: bus_target_model.sv */
`timescale 1ns/10ps
`default_nettype none
module bus_target_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic dphase,
  input wire logic bad,
  input wire logic dut_o,
  input wire logic dut_oe_n,
  output logic pin
);
  logic [1:0] flag_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 2'h0;
    end else begin
      flag_q <= {flag_q[0], dphase & bad};
    end
  end
  // pulled-up line, low while either party drives it low
  assign pin = (dut_oe_n | dut_o) & ~flag_q[1];
endmodule : bus_target_model
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import parity_report_pkg::*;
  logic clock;
  logic rst_n;
  logic [ADDR_W-1:0] ra;
  logic [REG_W-1:0] wd;
  logic ww;
  logic rr;
  logic mk;
  logic [1:0] dph, par, pois, rem;
  logic [DATA_W-1:0] ad [2];
  logic [CBE_W-1:0] cbe [2];
  xact_kind_e kind [2];
  dir_e dir [2];
  wire logic [REG_W-1:0] rdata;
  wire logic [1:0] pin, po, poe, det;
  wire logic se_o, se_oe, irq;
  int bad_count, total_checks;

  always #5 clock = ~clock;

  bridge_parity_error_report u_bridge_parity_error_report (
    .clock(clock), .rst_n(rst_n), .reg_addr(ra), .reg_wdata(wd), .reg_wr(ww), .reg_rd(rr), .reg_rdata(rdata),
    .pri_dphase(dph[0]), .pri_ad(ad[0]), .pri_cbe(cbe[0]), .pri_par(par[0]), .pri_kind(kind[0]),
    .pri_dir(dir[0]), .pri_poisoned(pois[0]), .sec_dphase(dph[1]), .sec_ad(ad[1]), .sec_cbe(cbe[1]),
    .sec_par(par[1]), .sec_kind(kind[1]), .sec_dir(dir[1]), .sec_poisoned(pois[1]),
    .primary_parity_err_n_i(pin[0]), .primary_parity_err_n_o(po[0]), .primary_parity_err_n_oe_n(poe[0]),
    .secondary_parity_err_n_i(pin[1]), .secondary_parity_err_n_o(po[1]), .secondary_parity_err_n_oe_n(poe[1]),
    .primary_system_err_n_o(se_o), .primary_system_err_n_oe_n(se_oe), .pri_err_detected(det[0]),
    .sec_err_detected(det[1]), .irq(irq)
  );
  for (genvar g = 0; g < 2; g++) begin : g_bus
    bus_target_model u_bus_target_model (
      .clock(clock), .rst_n(rst_n), .dphase(dph[g]), .bad(rem[g]), .dut_o(po[g]), .dut_oe_n(poe[g]), .pin(pin[g])
    );
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
    @(posedge clock);
    ra <= a;
    wd <= d;
    ww <= 1'b1;
    @(posedge clock);
    ww <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [REG_W-1:0] v);
    @(posedge clock);
    ra <= a;
    rr <= 1'b1;
    @(posedge clock);
    rr <= 1'b0;
    @(negedge clock);
    v = rdata;
  endtask : rd

  // returns in the cycle where own-error answers stand
  task automatic phase(input int b, input xact_kind_e k, input dir_e d, input logic bp, input logic rm,
                       input logic ps);
    @(posedge clock);
    dph[b] <= 1'b1;
    kind[b] <= k;
    dir[b] <= d;
    rem[b] <= rm;
    pois[b] <= ps;
    ad[b] <= ad[b] + 32'h0101_0F13;
    cbe[b] <= cbe[b] + 4'h5;
    @(posedge clock);
    dph[b] <= 1'b0;
    rem[b] <= 1'b0;
    par[b] <= ^{ad[b], cbe[b]} ^ bp;
    @(posedge clock);
    @(negedge clock);
  endtask : phase

  task automatic remote(input int b, input xact_kind_e k, input dir_e d, input logic ps, input logic [2:0] c,
                        input logic e);
    logic [31:0] v;
    wr(CTRL_OFS, {29'h0, c});
    phase(b, k, d, 1'b0, 1'b1, ps);
    repeat (3) @(negedge clock);
    chk("serr", e ? 2'b00 : 2'b11, {se_o, se_oe});
    rd(STATUS_OFS, v);
    chk("serr_st", {e, b == 1 && c[1]}, {v[ST_SERR], v[ST_SEC_MDPD]});
    chk("irq", e & mk, irq);
    wr(STATUS_OFS, 32'h3F);
    repeat (2) @(negedge clock);
    chk("irq_clr", 1'b0, irq);
  endtask : remote

  initial begin
    #200000;
    bad_count++;
    conclude();
  end

  initial begin
    logic [31:0] v;
    logic rcv;
    clock = 1'b0;
    rst_n = 1'b0;
    {ra, wd, ww, rr, mk, dph, par, pois, rem} = '0;
    for (int i = 0; i < 2; i++) begin
      ad[i] = 32'h5A0F_3C01;
      cbe[i] = 4'h3;
      kind[i] = KIND_READ;
      dir[i] = DIR_DOWN;
    end
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    for (int a = 0; a < 16; a += 4) begin
      rd(a[ADDR_W-1:0], v);
      chk("reset", 32'h0, v);
    end
    wr(4'hC, 32'hFFFF_FFFF);
    rd(4'hC, v);
    chk("unmapped", 32'h0, v);
    wr(CTRL_OFS, 32'hFFFF_FFFB);
    rd(CTRL_OFS, v);
    chk("ctrl", 32'h3, v);
    // every kind, direction and bus with bad parity
    for (int b = 0; b < 2; b++) for (int k = 0; k < 3; k++) for (int d = 0; d < 2; d++) begin
      phase(b, xact_kind_e'(k), dir_e'(d), 1'b1, 1'b0, 1'b0);
      rcv = (k == 0) == (d == (b ? 0 : 1));
      chk("det", rcv, det[b]);
      chk("perr", rcv ? 2'b00 : 2'b11, {po[b], poe[b]});
      repeat (3) @(negedge clock);
      rd(STATUS_OFS, v);
      chk("status", !rcv ? 32'h0 : b ? 32'h12 | (k == 0 && d == 0) : 32'h0C, v);
      wr(STATUS_OFS, 32'h3F);
    end
    wr(CTRL_OFS, 32'h0);
    phase(0, KIND_READ, DIR_UP, 1'b1, 1'b0, 1'b0);
    chk("det_p_off", 3'b111, {det[0], po[0], poe[0]});
    phase(1, KIND_POSTED, DIR_UP, 1'b1, 1'b0, 1'b0);
    chk("det_s_off", 3'b111, {det[1], po[1], poe[1]});
    wr(STATUS_OFS, 32'h3F);
    remote(1, KIND_POSTED, DIR_DOWN, 1'b0, 3'h7, 1'b1);
    wr(MASK_OFS, 32'hFFFF_FFE0);
    mk = 1'b1;
    rd(MASK_OFS, v);
    chk("mask", 32'h20, v);
    remote(1, KIND_POSTED, DIR_DOWN, 1'b0, 3'h7, 1'b1);
    remote(1, KIND_POSTED, DIR_DOWN, 1'b1, 3'h7, 1'b0);
    remote(1, KIND_POSTED, DIR_DOWN, 1'b0, 3'h3, 1'b0);
    remote(1, KIND_POSTED, DIR_DOWN, 1'b0, 3'h5, 1'b0);
    remote(0, KIND_POSTED, DIR_UP, 1'b0, 3'h7, 1'b1);
    remote(0, KIND_POSTED, DIR_UP, 1'b0, 3'h6, 1'b0);
    wr(CTRL_OFS, 32'h3);
    phase(1, KIND_DELAYED, DIR_DOWN, 1'b0, 1'b1, 1'b0);
    repeat (3) @(negedge clock);
    chk("serr_dw", 2'b11, {se_o, se_oe});
    phase(0, KIND_DELAYED, DIR_DOWN, 1'b0, 1'b0, 1'b0);
    chk("relay_p", 2'b00, {po[0], poe[0]});
    phase(0, KIND_DELAYED, DIR_UP, 1'b0, 1'b1, 1'b0);
    repeat (3) @(negedge clock);
    phase(1, KIND_DELAYED, DIR_UP, 1'b0, 1'b0, 1'b0);
    chk("relay_s", 2'b00, {po[1], poe[1]});
    wr(CTRL_OFS, 32'h1);
    phase(1, KIND_DELAYED, DIR_DOWN, 1'b0, 1'b1, 1'b0);
    repeat (3) @(negedge clock);
    phase(0, KIND_DELAYED, DIR_DOWN, 1'b0, 1'b0, 1'b0);
    chk("relay_off", 2'b11, {po[0], poe[0]});
    conclude();
  end
endmodule : tb_top
`default_nettype wire
